/* design/rpsm_status_monitor.sv */
// Receive port status, error flags and link frequency registers
module rpsm_status_monitor #(
  parameter int unsigned GATE_CYCLES = rpsm_pkg::GATE_CYCLES,
  parameter int unsigned MISS_CYCLES = rpsm_pkg::MISS_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Receiver core status, same clock domain
  input rpsm_pkg::rpsm_rx_status_t rx,
  input wire logic rx_read_port,
  input wire logic [15:0] parity_error_limit,
  // Prescaled link clock pin
  input wire logic link_clk_div,
  // Register read port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic lock_prev;
    logic crc_flag;
    logic lockchg_flag;
    logic seq_flag;
    logic par_flag;
    logic enc_flag;
    logic [15:0] par_cnt;
    logic [7:0] rdata;
    logic rvalid;
  } rpsm_mon_state_t;

  rpsm_mon_state_t s_r;
  rpsm_mon_state_t s_nxt;
  rpsm_pkg::rpsm_freq_t meas;

  logic rd_sts1;
  logic rd_sts2;
  logic rd_par_lo;
  logic lock_rise;
  logic par_clear;
  logic [15:0] cnt_base;
  logic [7:0] sts1;
  logic [7:0] sts2;
  logic [7:0] rd_byte;

  function automatic logic hit(input logic rd, input logic [7:0] addr,
                               input logic [7:0] off);
    hit = rd && (addr == off);
  endfunction

  // ----------------------------------------------------------------
  // Frequency meter
  // ----------------------------------------------------------------
  rpsm_freq_meter #(
    .GATE_CYCLES(GATE_CYCLES),
    .MISS_CYCLES(MISS_CYCLES)
  ) u_freq (
    .clk_sys(clk_sys),
    .srst(srst),
    .link_clk_div(link_clk_div),
    .meas(meas)
  );

  // ----------------------------------------------------------------
  // Register images
  // ----------------------------------------------------------------
  always_comb begin
    sts1 = rpsm_pkg::RESET_BYTE;
    sts1[rpsm_pkg::STS1_PORT_BIT] = rx_read_port;
    sts1[rpsm_pkg::STS1_CRC_BIT] = s_r.crc_flag;
    sts1[rpsm_pkg::STS1_LOCKCHG_BIT] = s_r.lockchg_flag;
    sts1[rpsm_pkg::STS1_SEQ_BIT] = s_r.seq_flag;
    sts1[rpsm_pkg::STS1_PAR_BIT] = s_r.par_flag;
    sts1[rpsm_pkg::STS1_PASS_BIT] = rx.rx_pass;
    sts1[rpsm_pkg::STS1_LOCK_BIT] = rx.receiver_locked;
    sts2 = rpsm_pkg::RESET_BYTE;
    sts2[rpsm_pkg::STS2_ENC_BIT] = s_r.enc_flag;
    sts2[rpsm_pkg::STS2_SETTLED_BIT] = meas.frequency_settled;
    sts2[rpsm_pkg::STS2_NOCLK_BIT] = meas.input_clock_missing;
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    unique case (reg_addr)
      rpsm_pkg::ADDR_STS1: rd_byte = sts1;
      rpsm_pkg::ADDR_STS2: rd_byte = sts2;
      rpsm_pkg::ADDR_FREQ_HI: rd_byte = meas.freq[15:8];
      rpsm_pkg::ADDR_FREQ_LO: rd_byte = meas.freq[7:0];
      rpsm_pkg::ADDR_PAR_HI: rd_byte = s_r.par_cnt[15:8];
      rpsm_pkg::ADDR_PAR_LO: rd_byte = s_r.par_cnt[7:0];
      // Unmapped offsets read as zero
      default: rd_byte = rpsm_pkg::RESET_BYTE;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    rd_sts1 = hit(reg_rd, reg_addr, rpsm_pkg::ADDR_STS1);
    rd_sts2 = hit(reg_rd, reg_addr, rpsm_pkg::ADDR_STS2);
    rd_par_lo = hit(reg_rd, reg_addr, rpsm_pkg::ADDR_PAR_LO);
    lock_rise = rx.receiver_locked & ~s_r.lock_prev;

    // Read answer, one cycle after the strobe
    s_nxt.rvalid = reg_rd;
    if (reg_rd) begin
      s_nxt.rdata = rd_byte;
    end

    // Latched flags: an event in the clearing cycle survives
    s_nxt.lock_prev = rx.receiver_locked;
    s_nxt.crc_flag = (s_r.crc_flag & ~rd_sts1) | rx.ctrl_channel_crc_fault;
    s_nxt.lockchg_flag = (s_r.lockchg_flag & ~rd_sts1) |
                         (rx.receiver_locked ^ s_r.lock_prev);
    s_nxt.seq_flag = (s_r.seq_flag & ~rd_sts1) | rx.ctrl_channel_sequence_fault;
    s_nxt.enc_flag = (s_r.enc_flag & ~rd_sts2) | rx.link_encoding_fault;

    // Parity count restarts on a low-byte read or on fresh lock
    par_clear = rd_par_lo | lock_rise;
    cnt_base = par_clear ? rpsm_pkg::RESET_WORD : s_r.par_cnt;
    if (rx.parity_error && cnt_base != 16'hffff) begin
      s_nxt.par_cnt = cnt_base + 16'h0001;
    end else begin
      s_nxt.par_cnt = cnt_base;
    end

    // Status read does not touch this flag; only a count clear does
    s_nxt.par_flag = (s_r.par_flag & ~par_clear) |
                     (s_nxt.par_cnt > parity_error_limit);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign reg_rvalid = s_r.rvalid;

endmodule // rpsm_status_monitor

/* design/rpsm_pkg.sv */
// Shared constants and carrier types for the receive port status monitor
package rpsm_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STS1 = 8'h4d;
  localparam logic [7:0] ADDR_STS2 = 8'h4e;
  localparam logic [7:0] ADDR_FREQ_HI = 8'h4f;
  localparam logic [7:0] ADDR_FREQ_LO = 8'h50;
  localparam logic [7:0] ADDR_PAR_HI = 8'h55;
  localparam logic [7:0] ADDR_PAR_LO = 8'h56;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned STS1_PORT_BIT = 6;
  localparam int unsigned STS1_CRC_BIT = 5;
  localparam int unsigned STS1_LOCKCHG_BIT = 4;
  localparam int unsigned STS1_SEQ_BIT = 3;
  localparam int unsigned STS1_PAR_BIT = 2;
  localparam int unsigned STS1_PASS_BIT = 1;
  localparam int unsigned STS1_LOCK_BIT = 0;
  localparam int unsigned STS2_ENC_BIT = 5;
  localparam int unsigned STS2_SETTLED_BIT = 2;
  localparam int unsigned STS2_NOCLK_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned REF_CLK_MHZ = 100;
  // Link clock arrives prescaled by this ratio on its pin
  localparam int unsigned FREQ_PRESCALE = 64;
  // Gate chosen so the edge count equals frequency in 1/256 MHz
  localparam int unsigned GATE_TIME_US = FREQ_PRESCALE * 256;
  localparam int unsigned GATE_CYCLES = GATE_TIME_US * REF_CLK_MHZ;
  localparam int unsigned MISS_TIME_US = 10;
  localparam int unsigned MISS_CYCLES = MISS_TIME_US * REF_CLK_MHZ;
  localparam int unsigned SETTLE_TOL = 1;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic receiver_locked;
    logic rx_pass;
    logic ctrl_channel_crc_fault;
    logic ctrl_channel_sequence_fault;
    logic link_encoding_fault;
    logic parity_error;
  } rpsm_rx_status_t;

  typedef struct packed {
    logic [15:0] freq;
    logic frequency_settled;
    logic input_clock_missing;
  } rpsm_freq_t;

endpackage : rpsm_pkg

/* design/rpsm_freq_meter.sv */
// Link frequency meter timed from the reference clock
module rpsm_freq_meter #(
  parameter int unsigned GATE_CYCLES = rpsm_pkg::GATE_CYCLES,
  parameter int unsigned MISS_CYCLES = rpsm_pkg::MISS_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Prescaled link clock pin
  input wire logic link_clk_div,
  // Measurement
  output rpsm_pkg::rpsm_freq_t meas
);

  localparam int unsigned GW = $clog2(GATE_CYCLES + 1);
  localparam int unsigned MW = $clog2(MISS_CYCLES + 1);
  localparam logic [GW-1:0] GATE_LAST = GW'(GATE_CYCLES - 1);
  localparam logic [MW-1:0] MISS_LAST = MW'(MISS_CYCLES - 1);
  localparam logic [15:0] TOL = 16'(rpsm_pkg::SETTLE_TOL);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic [GW-1:0] gate_cnt;
    logic [15:0] edge_cnt;
    logic [MW-1:0] miss_cnt;
    logic [15:0] result;
    logic have_prev;
    logic settled;
    logic missing;
  } rpsm_fm_state_t;

  rpsm_fm_state_t s_r;
  rpsm_fm_state_t s_nxt;
  logic edge_seen;

  function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync1 = link_clk_div;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.prev = s_r.sync2;
    edge_seen = s_r.sync2 & ~s_r.prev;
    // Gate length is counted in reference cycles, so the result scales with it
    if (s_r.gate_cnt == GATE_LAST) begin
      s_nxt.gate_cnt = '0;
      s_nxt.result = s_r.edge_cnt;
      s_nxt.edge_cnt = {15'h0000, edge_seen};
      s_nxt.have_prev = 1'b1;
      s_nxt.settled = s_r.have_prev && !s_r.missing &&
                      (abs_diff(s_r.edge_cnt, s_r.result) <= TOL);
    end else begin
      s_nxt.gate_cnt = s_r.gate_cnt + GW'(1);
      if (edge_seen && s_r.edge_cnt != 16'hffff) begin
        s_nxt.edge_cnt = s_r.edge_cnt + 16'h0001;
      end
    end
    if (edge_seen) begin
      s_nxt.miss_cnt = '0;
      s_nxt.missing = 1'b0;
    end else if (s_r.miss_cnt == MISS_LAST) begin
      s_nxt.missing = 1'b1;
    end else begin
      s_nxt.miss_cnt = s_r.miss_cnt + MW'(1);
    end
    // A lost clock invalidates any earlier settled verdict
    if (s_nxt.missing) begin
      s_nxt.settled = 1'b0;
      s_nxt.have_prev = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // One driver for the whole carrier: result, settled, missing
  assign meas = {s_r.result, s_r.settled, s_r.missing};

endmodule // rpsm_freq_meter

/* tb/rpsm_status_props.sv */
// Assertion checker for the receive port status monitor
module rpsm_status_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Observed ports
  input rpsm_pkg::rpsm_rx_status_t rx,
  input wire logic rx_read_port,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic rd1;
  logic rd2;
  assign rd1 = reg_rd && reg_addr == rpsm_pkg::ADDR_STS1;
  assign rd2 = reg_rd && reg_addr == rpsm_pkg::ADDR_STS2;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_ans; 1'b1 |=> reg_rvalid == $past(reg_rd); endproperty
  a_ans: assert property (p_ans) else $error("read answer timing wrong");
  property p_port; rd1 |=> reg_rdata[6] == $past(rx_read_port); endproperty
  a_port: assert property (p_port) else $error("port index wrong");
  property p_crc; rx.ctrl_channel_crc_fault ##1 !reg_rd ##1 rd1 |=> reg_rdata[5]; endproperty
  a_crc: assert property (p_crc) else $error("crc flag lost");
  property p_lchg;
    !$past(srst) && $changed(rx.receiver_locked) ##1 !reg_rd ##1 rd1 |=> reg_rdata[4];
  endproperty
  a_lchg: assert property (p_lchg) else $error("lock change flag lost");
  property p_seq;
    rx.ctrl_channel_sequence_fault ##1 !reg_rd ##1 rd1 |=> reg_rdata[3];
  endproperty
  a_seq: assert property (p_seq) else $error("sequence flag lost");
  property p_pass; rd1 |=> reg_rdata[1] == $past(rx.rx_pass); endproperty
  a_pass: assert property (p_pass) else $error("pass bit wrong");
  property p_lock; rd1 |=> reg_rdata[0] == $past(rx.receiver_locked); endproperty
  a_lock: assert property (p_lock) else $error("lock bit wrong");
  property p_enc; rx.link_encoding_fault ##1 !reg_rd ##1 rd2 |=> reg_rdata[5]; endproperty
  a_enc: assert property (p_enc) else $error("encoding flag lost");
  property p_unm; reg_rd && reg_addr == 8'h51 |=> reg_rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule // rpsm_status_props

bind rpsm_status_monitor rpsm_status_props u_props (.clk_sys(clk_sys), .srst(srst), .rx(rx),
  .rx_read_port(rx_read_port), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

/* tb/rpsm_far_end.sv */
// Remote serializer model giving the prescaled link clock
module rpsm_far_end (
  // Control from bench
  input wire logic run,
  input wire logic [15:0] half_ns,
  // Prescaled link clock
  output logic link_clk_div
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clock parks low when the link is down
  initial begin
    link_clk_div = 1'b0;
    forever begin
      if (run) #(half_ns) link_clk_div = ~link_clk_div;
      else #1 link_clk_div = 1'b0;
    end
  end
endmodule // rpsm_far_end

/* tb/tb.sv */
// Self-checking bench for the receive port status monitor
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int GATE = 3000;
  localparam int MISS = 50;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  rpsm_pkg::rpsm_rx_status_t rx = '0;
  logic rx_read_port = 1'b0;
  logic [15:0] parity_error_limit = 16'h0000;
  logic [7:0] reg_addr = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic link_clk_div;
  logic run = 1'b0;
  logic [15:0] half_ns = 16'h0014;
  int n_errors = 0;
  int n_tests = 0;
  logic [7:0] d, h;
  logic [2:0] ev;
  logic lk, plk, ps, pt;
  int lim;

  always #5 clk_sys = ~clk_sys;

  rpsm_status_monitor #(.GATE_CYCLES(GATE), .MISS_CYCLES(MISS)) dut (.clk_sys(clk_sys),
    .srst(srst), .rx(rx), .rx_read_port(rx_read_port), .parity_error_limit(parity_error_limit),
    .link_clk_div(link_clk_div), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  rpsm_far_end far (.run(run), .half_ns(half_ns), .link_clk_div(link_clk_div));

  // ----------------------------------------------------------------
  // Expectations and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [15:0] fexp(input logic [15:0] hn);
    return 16'(GATE * 10 / (2 * int'(hn)));
  endfunction
  function automatic logic [7:0] sts1(input logic p, c, g, s, a, l);
    return {1'b0, p, c, g, s, 1'b0, a, l};
  endfunction
  task automatic print_verdict();
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    int k;
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    k = 0;
    while (reg_rvalid !== 1'b1 && k < 8) begin
      @(negedge clk_sys);
      k++;
    end
    if (k == 8) begin
      n_errors++;
      print_verdict();
    end
    q = reg_rdata;
  endtask
  task automatic rc(input logic [7:0] a, e);
    rd(a, d);
    chk(d, e);
  endtask
  // Bytes may come from different gates, hence the tolerance
  task automatic chkf(input logic [15:0] e);
    rd(rpsm_pkg::ADDR_FREQ_HI, h);
    rd(rpsm_pkg::ADDR_FREQ_LO, d);
    n_tests++;
    if (({h, d} >= e - 16'h0001 && {h, d} <= e + 16'h0001) !== 1'b1) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, {h, d}, e);
    end
  endtask
  task automatic par(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      rx.parity_error = 1'b1;
    end
    @(negedge clk_sys);
    rx.parity_error = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(79998));
    repeat (5) @(negedge clk_sys);
    srst = 1'b0;
    rc(rpsm_pkg::ADDR_STS1, 8'h00);
    rc(rpsm_pkg::ADDR_FREQ_HI, 8'h00);
    rc(8'h51, 8'h00);
    run = 1'b1;
    repeat (3 * GATE + 100) @(negedge clk_sys);
    rc(rpsm_pkg::ADDR_STS2, 8'h04);
    chkf(fexp(16'h0014));
    half_ns = 16'h0028;
    repeat (3 * GATE + 100) @(negedge clk_sys);
    chkf(fexp(16'h0028));
    run = 1'b0;
    repeat (MISS + 20) @(negedge clk_sys);
    rd(rpsm_pkg::ADDR_STS2, d);
    chk(d & 8'h02, 8'h02);
    run = 1'b1;
    repeat (20) @(negedge clk_sys);
    rd(rpsm_pkg::ADDR_STS2, d);
    chk(d & 8'h02, 8'h00);
    plk = 1'b0;
    for (int i = 0; i < 24; i++) begin
      @(negedge clk_sys);
      ev = (i == 0) ? 3'h7 : 3'($urandom());
      lk = 1'($urandom());
      ps = 1'($urandom());
      pt = 1'($urandom());
      {rx.ctrl_channel_crc_fault, rx.ctrl_channel_sequence_fault, rx.link_encoding_fault} = ev;
      rx.receiver_locked = lk;
      rx.rx_pass = ps;
      rx_read_port = pt;
      @(negedge clk_sys);
      {rx.ctrl_channel_crc_fault, rx.ctrl_channel_sequence_fault, rx.link_encoding_fault} = 3'h0;
      rc(rpsm_pkg::ADDR_STS1, sts1(pt, ev[2], lk ^ plk, ev[1], ps, lk));
      rc(rpsm_pkg::ADDR_STS1, sts1(pt, 1'b0, 1'b0, 1'b0, ps, lk));
      rd(rpsm_pkg::ADDR_STS2, d);
      chk(d & 8'h20, {2'h0, ev[0], 5'h00});
      plk = lk;
    end
    lim = 1 + ($urandom() % 6);
    parity_error_limit = 16'(lim);
    par(lim);
    rd(rpsm_pkg::ADDR_STS1, d);
    chk(d & 8'h04, 8'h00);
    par(1);
    rd(rpsm_pkg::ADDR_STS1, d);
    chk(d & 8'h04, 8'h04);
    rd(rpsm_pkg::ADDR_STS1, d);
    chk(d & 8'h04, 8'h04);
    rc(rpsm_pkg::ADDR_PAR_HI, 8'h00);
    rc(rpsm_pkg::ADDR_PAR_LO, 8'(lim + 1));
    rd(rpsm_pkg::ADDR_STS1, d);
    chk(d & 8'h04, 8'h00);
    rc(rpsm_pkg::ADDR_PAR_LO, 8'h00);
    rc(rpsm_pkg::ADDR_PAR_HI, 8'h00);
    print_verdict();
  end
endmodule // tb
